// ==== rtl/gpio_defaults.sv ====
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Contract
// [R01] after reset out_a floats in ten-bit modes, else drives link status
// [R02] after reset out_b floats in ten-bit modes, else drives carrier sense
// [R03] out_a strap low: gp pin a floats after reset
// [R04] out_a strap high: gp pin a drives the 125 MHz clock after reset
// [R05] gp pins b to g float right after reset
// [R06] shared pins d to g act as gpio only in MII, RGMII, RTBI modes
// [R07] software may change every pin's function after reset
// [R08] serial tx clock output off after reset, on only when its bit is set
// [R09] loss-of-signal low means normal, high means signal lost
// [R10] receive clock recovered internally, no receive clock input
// [R11] strap pins are sampled while reset is held
// [R12] status outputs registered, loss-of-signal synchronised first
module gpio_defaults (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire gpio_pkg::par_mode_t i_par_mode,
  input wire logic i_link_up,
  input wire logic i_carrier_sense,
  input wire logic i_clk_125,
  input wire logic i_cdr_lock,
  input wire logic i_loss_of_signal_in,
  input wire logic i_general_out_a,
  output logic o_general_out_a,
  output logic o_general_out_a_oe,
  output logic o_general_out_b,
  output logic o_general_out_b_oe,
  input wire logic [6:0] i_gp_pin,
  output logic [6:0] o_gp_pin,
  output logic [6:0] o_gp_pin_oe,
  output logic o_tx_clock_out_enable,
  output logic o_loss_of_signal,
  output logic o_irq
);
  // ==========================================================
  // reset release
  // ==========================================================
  logic rst_meta_q;
  logic rst_n_q;

  // left ungated by the clock enable so reset always releases
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [9:0] sync_in;
  logic [9:0] sync_out;
  logic strap_pin_s;
  logic los_s;
  logic cdr_lock_s;
  logic [6:0] gp_in_s;

  assign sync_in = {i_gp_pin, i_cdr_lock, i_loss_of_signal_in,
                    i_general_out_a};

  sync_pair #(.WIDTH(10)) u_sync (
    .i_clock(i_clock),
    .i_clk_en(i_clk_en),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign strap_pin_s = sync_out[0];
  assign los_s = sync_out[1]; // [R12]
  assign cdr_lock_s = sync_out[2];
  assign gp_in_s = sync_out[9:3];

  // ==========================================================
  // strap capture
  // ==========================================================
  logic strap_q;

  // pins are released while reset holds, so the last sample wins
  always_ff @(posedge i_clock) begin
    if (i_clk_en && !rst_n_q) begin
      strap_q <= strap_pin_s; // [R11]
    end
  end

  // ==========================================================
  // status registers
  // ==========================================================
  gpio_pkg::link_status_t stat_q;
  gpio_pkg::link_status_t stat_prev_q;

  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= '0;
      stat_prev_q <= '0;
    end else if (i_clk_en) begin
      stat_q.link_up <= i_link_up; // [R12]
      stat_q.carrier <= i_carrier_sense; // [R12]
      stat_q.los <= los_s; // [R09]
      // recovered-clock lock comes from the on-chip cdr
      stat_q.cdr_lock <= cdr_lock_s; // [R10]
      stat_prev_q <= stat_q;
    end
  end

  assign o_loss_of_signal = stat_q.los; // [R09]

  // ==========================================================
  // avalon slave: one wait cycle on every access
  // ==========================================================
  logic ack_q;
  logic req;
  logic wr_acc;

  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_acc = i_avs_write & ack_q & i_clk_en;

  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else if (i_clk_en) begin
      ack_q <= req & ~ack_q;
    end
  end

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] wmerged;
  logic [17:0] func_q;
  logic [8:0] out_q;
  logic txclk_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_stat_q;

  always_comb begin
    wmerged = 32'h00000000;
    unique case (i_avs_address)
      gpio_pkg::OFS_CTRL: wmerged = be_merge({31'h0, txclk_q},
                                             i_avs_writedata,
                                             i_avs_byteenable);
      gpio_pkg::OFS_FUNC: wmerged = be_merge({14'h0, func_q},
                                             i_avs_writedata,
                                             i_avs_byteenable);
      gpio_pkg::OFS_OUT: wmerged = be_merge({23'h0, out_q},
                                            i_avs_writedata,
                                            i_avs_byteenable);
      gpio_pkg::OFS_IRQ_MASK: wmerged = be_merge({28'h0, irq_mask_q},
                                                 i_avs_writedata,
                                                 i_avs_byteenable);
      default: wmerged = be_merge(32'h00000000, i_avs_writedata,
                                  i_avs_byteenable);
    endcase
  end

  // ==========================================================
  // software registers
  // ==========================================================
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      txclk_q <= gpio_pkg::TXCLK_RST;
      func_q <= gpio_pkg::FUNC_RST;
      out_q <= gpio_pkg::OUT_RST;
      irq_mask_q <= gpio_pkg::IRQ_MASK_RST;
    end else if (wr_acc) begin
      unique case (i_avs_address)
        gpio_pkg::OFS_CTRL:
          txclk_q <= wmerged[gpio_pkg::CTRL_TXCLK_BIT]; // [R08]
        gpio_pkg::OFS_FUNC: func_q <= wmerged[17:0]; // [R07]
        gpio_pkg::OFS_OUT: out_q <= wmerged[8:0];
        gpio_pkg::OFS_IRQ_MASK: irq_mask_q <= wmerged[3:0];
        default: ;
      endcase
    end
  end

  assign o_tx_clock_out_enable = txclk_q; // [R08]

  // ==========================================================
  // interrupts: sticky, write one to clear, set wins
  // ==========================================================
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;

  assign irq_ev[gpio_pkg::IRQ_LINK_CHG] = stat_q.link_up ^
                                          stat_prev_q.link_up;
  assign irq_ev[gpio_pkg::IRQ_LOS_ON] = stat_q.los & ~stat_prev_q.los;
  assign irq_ev[gpio_pkg::IRQ_LOS_OFF] = ~stat_q.los & stat_prev_q.los;
  assign irq_ev[gpio_pkg::IRQ_CDR_LOST] = ~stat_q.cdr_lock &
                                          stat_prev_q.cdr_lock;
  assign irq_clr = (wr_acc && i_avs_address == gpio_pkg::OFS_IRQ_STAT) ?
                   wmerged[3:0] : 4'h0;

  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= 4'h0;
    end else if (i_clk_en) begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // read data
  // ==========================================================
  logic [6:0] status_word;

  assign status_word = {gpio_pkg::is_nibble(i_par_mode),
                        gpio_pkg::is_ten_bit(i_par_mode), strap_q,
                        stat_q.cdr_lock, stat_q.los, stat_q.carrier,
                        stat_q.link_up};

  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_clk_en && i_avs_read && !ack_q) begin
      unique case (i_avs_address)
        gpio_pkg::OFS_CTRL: o_avs_readdata <= {31'h0, txclk_q};
        gpio_pkg::OFS_FUNC: o_avs_readdata <= {14'h0, func_q};
        gpio_pkg::OFS_OUT: o_avs_readdata <= {23'h0, out_q};
        gpio_pkg::OFS_PIN_IN: o_avs_readdata <= {25'h0, gp_in_s};
        gpio_pkg::OFS_STATUS: o_avs_readdata <= {25'h0, status_word};
        gpio_pkg::OFS_IRQ_STAT: o_avs_readdata <= {28'h0, irq_stat_q};
        gpio_pkg::OFS_IRQ_MASK: o_avs_readdata <= {28'h0, irq_mask_q};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // pin drivers
  // ==========================================================
  function automatic logic [1:0] fn_of(input logic [17:0] f,
                                       input int idx);
    return f[gpio_pkg::FN_W*idx +: gpio_pkg::FN_W];
  endfunction

  logic ten_bit;
  logic nibble;
  gpio_pkg::pin_drive_t drv_d [gpio_pkg::NUM_PINS];
  gpio_pkg::pin_drive_t drv_q [gpio_pkg::NUM_PINS];
  logic clk_sel_d;
  logic clk_sel_q;

  assign ten_bit = gpio_pkg::is_ten_bit(i_par_mode);
  assign nibble = gpio_pkg::is_nibble(i_par_mode);

  always_comb begin
    clk_sel_d = 1'b0;
    for (int i = 0; i < gpio_pkg::NUM_PINS; i++) begin
      drv_d[i] = '{out: 1'b0, oe: 1'b0};
      unique case (fn_of(func_q, i))
        gpio_pkg::FN_DEFAULT: begin
          if (i == gpio_pkg::IDX_OUT_A) begin
            drv_d[i] = '{out: stat_q.link_up, oe: !ten_bit}; // [R01]
          end else if (i == gpio_pkg::IDX_OUT_B) begin
            drv_d[i] = '{out: stat_q.carrier, oe: !ten_bit}; // [R02]
          end else if (i == gpio_pkg::IDX_GP_BASE) begin
            drv_d[i] = '{out: 1'b0, oe: strap_q}; // [R03]
            clk_sel_d = strap_q; // [R04]
          end
        end
        gpio_pkg::FN_HIZ: drv_d[i] = '{out: 1'b0, oe: 1'b0}; // [R07]
        gpio_pkg::FN_REG: drv_d[i] = '{out: out_q[i], oe: 1'b1}; // [R07]
        gpio_pkg::FN_IRQ: drv_d[i] = '{out: o_irq, oe: 1'b1}; // [R07]
      endcase
      // shared pins belong to the tx datapath in byte-wide modes
      if (i >= gpio_pkg::IDX_GP_BASE + gpio_pkg::GP_SHARED_LO && !nibble) begin
        drv_d[i] = '{out: 1'b0, oe: 1'b0}; // [R06]
      end
    end
  end

  // all drivers off in reset so the strap pin can be sampled
  always_ff @(posedge i_clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < gpio_pkg::NUM_PINS; i++) begin
        drv_q[i] <= '{out: 1'b0, oe: 1'b0}; // [R05]
      end
      clk_sel_q <= 1'b0;
    end else if (i_clk_en) begin
      drv_q <= drv_d;
      clk_sel_q <= clk_sel_d;
    end
  end

  assign o_general_out_a = drv_q[gpio_pkg::IDX_OUT_A].out;
  assign o_general_out_a_oe = drv_q[gpio_pkg::IDX_OUT_A].oe;
  assign o_general_out_b = drv_q[gpio_pkg::IDX_OUT_B].out;
  assign o_general_out_b_oe = drv_q[gpio_pkg::IDX_OUT_B].oe;

  // the 125 MHz clock cannot be re-timed at 10 MHz, it is muxed through
  always_comb begin
    for (int g = 0; g < gpio_pkg::NUM_GP; g++) begin
      o_gp_pin[g] = drv_q[gpio_pkg::IDX_GP_BASE + g].out;
      o_gp_pin_oe[g] = drv_q[gpio_pkg::IDX_GP_BASE + g].oe;
    end
    if (clk_sel_q) begin
      o_gp_pin[0] = i_clk_125; // [R04]
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  property p_out_a_link;
    @(posedge i_clock) disable iff (!rst_n_q)
    $past(i_clk_en && rst_n_q) &&
    $past(fn_of(func_q, 0) == gpio_pkg::FN_DEFAULT)
    |-> o_general_out_a_oe == !$past(ten_bit) &&
        o_general_out_a == $past(stat_q.link_up);
  endproperty
  a_out_a_link: assert property (p_out_a_link) // [R01]
    else $error("out_a default drive wrong");

  property p_out_b_crs;
    @(posedge i_clock) disable iff (!rst_n_q)
    $past(i_clk_en && rst_n_q) &&
    $past(fn_of(func_q, 1) == gpio_pkg::FN_DEFAULT)
    |-> o_general_out_b_oe == !$past(ten_bit) &&
        o_general_out_b == $past(stat_q.carrier);
  endproperty
  a_out_b_crs: assert property (p_out_b_crs) // [R02]
    else $error("out_b default drive wrong");

  property p_gp_a_float;
    @(posedge i_clock) disable iff (!rst_n_q)
    $past(i_clk_en && rst_n_q) && !strap_q &&
    $past(fn_of(func_q, 2) == gpio_pkg::FN_DEFAULT)
    |-> !o_gp_pin_oe[0] && !clk_sel_q;
  endproperty
  a_gp_a_float: assert property (p_gp_a_float) // [R03]
    else $error("gp pin a driven with strap low");

  property p_gp_a_clock;
    @(posedge i_clock) disable iff (!rst_n_q)
    $past(i_clk_en && rst_n_q) && strap_q &&
    $past(fn_of(func_q, 2) == gpio_pkg::FN_DEFAULT)
    |-> o_gp_pin_oe[0] && clk_sel_q && o_gp_pin[0] == i_clk_125;
  endproperty
  a_gp_a_clock: assert property (p_gp_a_clock) // [R04]
    else $error("gp pin a not clocking with strap high");

  property p_gp_rest_float;
    @(posedge i_clock) $rose(rst_n_q) |-> o_gp_pin_oe[6:1] == 6'h00;
  endproperty
  a_gp_rest_float: assert property (p_gp_rest_float) // [R05]
    else $error("gp pins driven at reset release");

  property p_shared;
    @(posedge i_clock) disable iff (!rst_n_q)
    $past(i_clk_en) && !$past(nibble) |-> o_gp_pin_oe[6:3] == 4'h0;
  endproperty
  a_shared: assert property (p_shared) // [R06]
    else $error("shared pin driven outside nibble mode");

  property p_txclk;
    @(posedge i_clock) disable iff (!rst_n_q)
    $rose(o_tx_clock_out_enable) |->
    $past(wr_acc) && $past(i_avs_address) == gpio_pkg::OFS_CTRL;
  endproperty
  a_txclk: assert property (p_txclk) // [R08]
    else $error("tx clock enabled without a write");

  property p_los_irq;
    @(posedge i_clock) disable iff (!rst_n_q)
    i_clk_en && $rose(o_loss_of_signal)
    |=> irq_stat_q[gpio_pkg::IRQ_LOS_ON];
  endproperty
  a_los_irq: assert property (p_los_irq) // [R09]
    else $error("loss of signal event lost");

endmodule // gpio_defaults

// ==== rtl/gpio_pkg.sv ====
package gpio_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  // ==========================================================
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_FUNC = 5'h04;
  localparam logic [4:0] OFS_OUT = 5'h08;
  localparam logic [4:0] OFS_PIN_IN = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

  // ==========================================================
  // field layouts
  // ==========================================================
  localparam int CTRL_TXCLK_BIT = 0;
  localparam int NUM_PINS = 9;
  localparam int NUM_GP = 7;
  localparam int FN_W = 2;
  localparam int IDX_OUT_A = 0;
  localparam int IDX_OUT_B = 1;
  localparam int IDX_GP_BASE = 2;
  localparam int GP_SHARED_LO = 3;
  localparam int GP_SHARED_HI = 6;

  localparam logic [1:0] FN_DEFAULT = 2'h0;
  localparam logic [1:0] FN_HIZ = 2'h1;
  localparam logic [1:0] FN_REG = 2'h2;
  localparam logic [1:0] FN_IRQ = 2'h3;

  localparam int ST_LINK = 0;
  localparam int ST_CRS = 1;
  localparam int ST_LOS = 2;
  localparam int ST_CDR_LOCK = 3;
  localparam int ST_STRAP = 4;
  localparam int ST_TEN_BIT = 5;
  localparam int ST_NIBBLE = 6;

  localparam int IRQ_W = 4;
  localparam int IRQ_LINK_CHG = 0;
  localparam int IRQ_LOS_ON = 1;
  localparam int IRQ_LOS_OFF = 2;
  localparam int IRQ_CDR_LOST = 3;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [17:0] FUNC_RST = 18'h00000;
  localparam logic [8:0] OUT_RST = 9'h000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic TXCLK_RST = 1'b0;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    PM_GMII,
    PM_MII,
    PM_RGMII,
    PM_TBI,
    PM_RTBI
  } par_mode_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic cdr_lock;
    logic los;
    logic carrier;
    logic link_up;
  } link_status_t;

  function automatic logic is_ten_bit(input par_mode_t m);
    return (m == PM_TBI) || (m == PM_RTBI);
  endfunction

  function automatic logic is_nibble(input par_mode_t m);
    return (m == PM_MII) || (m == PM_RGMII) || (m == PM_RTBI);
  endfunction

endpackage

// ==== rtl/sync_pair.sv ====
`timescale 1ns/1ps
// two-stage synchroniser; no reset so it also runs while reset is held
module sync_pair #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clock) begin
    if (i_clk_en) begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // sync_pair

// ==== dv/sfp_model.sv ====
`timescale 1ns/1ps
// far side of the pins: optical module, strap resistor, pin loads
module sfp_model (
  input wire logic i_strap_hi,
  input wire logic i_los,
  input wire logic i_drive_a,
  input wire logic i_drive_a_oe,
  input wire logic [6:0] i_gp_out,
  input wire logic [6:0] i_gp_oe,
  output logic o_pin_a,
  output logic o_los_in,
  output logic o_clk_125,
  output logic [6:0] o_gp_level
);
  // strap resistor sets the level only while nobody drives the pin
  assign o_pin_a = i_drive_a_oe ? i_drive_a : i_strap_hi;
  // high means the module lost its light, low is normal
  assign o_los_in = i_los;
  // released pins sit on board pull-downs
  assign o_gp_level = i_gp_out & i_gp_oe;
  // fast clock not tied to the bus clock, so mux checks see it move
  initial begin
    o_clk_125 = 1'b0;
    forever #4 o_clk_125 = ~o_clk_125;
  end
endmodule // sfp_model

// ==== dv/gpio_reset_defaults_and_serial_status_tb.sv ====
`timescale 1ns/1ps
module gpio_reset_defaults_and_serial_status_tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic en = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitreq;
  gpio_pkg::par_mode_t mode = gpio_pkg::PM_GMII;
  logic link = 1'b0;
  logic crs = 1'b0;
  logic cdr = 1'b1;
  logic los = 1'b0;
  logic strap = 1'b0;
  logic pin_a, los_in, oa, oa_oe, ob, ob_oe, txen, los_q, irq, clk125;
  logic [6:0] gp_lvl, gp_out, gp_oe;
  logic [31:0] v;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;

  gpio_defaults gpio_defaults_inst (
    .i_clock(clock), .i_arst_n(arst_n), .i_clk_en(en),
    .i_avs_address(address), .i_avs_read(read), .i_avs_write(write),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_par_mode(mode), .i_link_up(link), .i_carrier_sense(crs),
    .i_clk_125(clk125), .i_cdr_lock(cdr), .i_loss_of_signal_in(los_in),
    .i_general_out_a(pin_a), .o_general_out_a(oa),
    .o_general_out_a_oe(oa_oe), .o_general_out_b(ob),
    .o_general_out_b_oe(ob_oe), .i_gp_pin(gp_lvl), .o_gp_pin(gp_out),
    .o_gp_pin_oe(gp_oe), .o_tx_clock_out_enable(txen),
    .o_loss_of_signal(los_q), .o_irq(irq)
  );

  sfp_model sfp_model_inst (
    .i_strap_hi(strap), .i_los(los), .i_drive_a(oa),
    .i_drive_a_oe(oa_oe), .i_gp_out(gp_out), .i_gp_oe(gp_oe),
    .o_pin_a(pin_a), .o_los_in(los_in), .o_clk_125(clk125),
    .o_gp_level(gp_lvl)
  );

  initial begin
    forever #50 clock = ~clock;
  end

  // the whole run needs fewer than two hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ==========================================================
  // access tasks
  // ==========================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    wdata <= d;
    write <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    v = rdata;
    read <= 1'b0;
    chk(v & ((a == gpio_pkg::OFS_PIN_IN) ? 32'h7e : 32'hffffffff), e);
  endtask

  task automatic do_reset(input logic s);
    @(posedge clock);
    arst_n <= 1'b0;
    strap <= s;
    cyc(4);
    arst_n <= 1'b1;
    cyc(4);
  endtask

  task automatic test_done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    do_reset(1'b0);
    chk(gp_oe, 7'h00);
    chk({oa_oe, oa, ob_oe, ob}, 4'ha);
    rchk(gpio_pkg::OFS_STATUS, 32'h08);
    test_done("strap_low");
    mode <= gpio_pkg::PM_TBI;
    do_reset(1'b1);
    chk({oa_oe, ob_oe, txen}, 3'b000);
    chk(gp_oe, 7'h01);
    // two looks half a fast period apart, so one sees the clock high
    #1;
    chk(gp_out[0], clk125);
    #4;
    chk(gp_out[0], clk125);
    rchk(gpio_pkg::OFS_STATUS, 32'h38);
    mode <= gpio_pkg::PM_GMII;
    link <= 1'b1;
    crs <= 1'b1;
    cyc(4);
    chk({oa_oe, oa, ob_oe, ob}, 4'hf);
    // frozen while the enable is low, so the dip in link is never seen
    en <= 1'b0;
    link <= 1'b0;
    cyc(4);
    chk({oa_oe, oa}, 2'b11);
    link <= 1'b1;
    en <= 1'b1;
    test_done("strap_high");
    wr(gpio_pkg::OFS_CTRL, 32'h1);
    cyc(2);
    chk(txen, 1'b1);
    rchk(gpio_pkg::OFS_CTRL, 32'h1);
    wr(gpio_pkg::OFS_CTRL, 32'h0);
    cyc(2);
    chk(txen, 1'b0);
    test_done("tx_clock");
    // out_a floats, gp b and shared d driven from the output word
    wr(gpio_pkg::OFS_FUNC, 32'h881);
    wr(gpio_pkg::OFS_OUT, 32'h28);
    cyc(3);
    chk({oa_oe, gp_oe[3:1], gp_out[1]}, 5'b00011);
    mode <= gpio_pkg::PM_RGMII;
    cyc(3);
    chk({gp_oe[3], gp_out[3]}, 2'b11);
    // ten-bit and nibble at once: out_b floats, shared pins stay free
    mode <= gpio_pkg::PM_RTBI;
    cyc(3);
    chk({ob_oe, gp_oe[3]}, 2'b01);
    mode <= gpio_pkg::PM_MII;
    rchk(gpio_pkg::OFS_PIN_IN, 32'h0a);
    test_done("functions");
    wr(gpio_pkg::OFS_IRQ_STAT, 32'hf);
    wr(gpio_pkg::OFS_IRQ_MASK, 32'h8);
    los <= 1'b1;
    cyc(5);
    chk({los_q, irq}, 2'b10);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h2);
    wr(gpio_pkg::OFS_IRQ_MASK, 32'ha);
    cyc(1);
    chk(irq, 1'b1);
    // out_b now follows the interrupt line
    wr(gpio_pkg::OFS_FUNC, 32'h88d);
    cyc(2);
    chk({ob_oe, ob}, 2'b11);
    cdr <= 1'b0;
    cyc(5);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'ha);
    rchk(gpio_pkg::OFS_STATUS, 32'h57);
    wr(gpio_pkg::OFS_STATUS, 32'hffffffff);
    rchk(gpio_pkg::OFS_STATUS, 32'h57);
    wr(5'h1c, 32'hffffffff);
    rchk(5'h1c, 32'h0);
    wr(gpio_pkg::OFS_IRQ_STAT, 32'h2);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h8);
    wr(gpio_pkg::OFS_IRQ_STAT, 32'h8);
    cyc(1);
    chk(irq, 1'b0);
    cyc(1);
    chk({ob_oe, ob}, 2'b10);
    los <= 1'b0;
    cyc(5);
    chk(los_q, 1'b0);
    rchk(gpio_pkg::OFS_IRQ_STAT, 32'h4);
    rchk(gpio_pkg::OFS_IRQ_MASK, 32'ha);
    test_done("loss_of_signal");
    end_of_test();
  end
endmodule // gpio_reset_defaults_and_serial_status_tb
